/* File: irq_vector_ctrl.sv */
// Interrupt enable registers, merged line and relocated vectoring
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Timer-0, timer-1 and serial sources supported, plus extra lines five and six.
// - Line six carries the real-time kernel tick interrupt.
// - All non-standard internal sources are ORed into line five.
// - External pin interrupts zero and one never request service.
// - Serviced interrupts jump to the relocated vectors at 0x20xx.
// - Line five waits eight extra instruction cycles before its vector.
// - After reset and finished download, jump to 0x2000.
// - Power-up or watchdog reset clears the interrupt control registers.
// - USB bus reset also clears them while propagate enable is set.
// - Enable bit 1 gates timer-0.
// - Enable bit 3 gates timer-1.
// - Enable bit 4 gates the serial port.
// - Enable bit 5 gates merged line five.
// - Enable bit 7 is a global gate over every source.
// - Line five is level sensitive, active low, while any internal source pends.
module irq_vector_ctrl
	import irq_vector_pkg::*;
#(
	parameter int INT_SRC_N      = 8,
	parameter int CLKS_PER_INSTR = 4
) (
	input  wire logic                                clk,
	input  wire logic                                resetn,
	input  wire logic                                usb_bus_reset,
	input  wire logic                                usb_reset_propagate_enable,
	input  wire logic [7:0]                          sfr_addr,
	input  wire logic                                sfr_wr,
	input  wire logic                                sfr_rd,
	input  wire logic [7:0]                          sfr_wdata,
	output logic      [7:0]                          sfr_rdata,
	input  wire logic                                timer_zero_pending,
	input  wire logic                                timer_one_pending,
	input  wire logic                                serial_port_pending,
	input  wire logic [INT_SRC_N-1:0]                internal_pending,
	input  wire logic                                kernel_tick_pending,
	output logic      [irq_vector_pkg::SRC_COUNT-1:0] irq_request,
	output logic                                     merged_internal_irq_line_n,
	output logic                                     external_pin_irq_zero,
	output logic                                     external_pin_irq_one,
	input  wire logic                                download_done,
	input  wire logic                                service_req,
	input  wire logic [irq_vector_pkg::SRC_IDX_W-1:0] service_src,
	output logic                                     jump_valid,
	output logic      [15:0]                         jump_addr
);
	import irq_vector_pkg::*;

	typedef enum logic [1:0] {BOOT_WAIT, RUN, MERGED_DELAY} flow_type;

	// Relocated vector per serviced source
	function automatic logic [15:0] vector_of(input logic [2:0] src);
		logic [15:0] v;
		v = FW_RESET_VEC;
		case (src)
			SRC_TIMER0: v = TIMER0_VEC;
			SRC_TIMER1: v = TIMER1_VEC;
			SRC_SERIAL: v = SERIAL_VEC;
			SRC_MERGED: v = MERGED_VEC;
			SRC_KERNEL: v = KERNEL_VEC;
			default:    v = FW_RESET_VEC;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register file

	logic [7:0] interrupt_enable_q;
	logic [7:0] interrupt_enable_d;
	logic [7:0] kernel_enable_q;
	logic [7:0] kernel_enable_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       soft_clear;

	// USB reset only reaches these registers when propagation is enabled
	assign soft_clear = usb_bus_reset & usb_reset_propagate_enable;

	// Masked writes keep reserved bits at zero
	always_comb begin
		interrupt_enable_d = interrupt_enable_q;
		kernel_enable_d    = kernel_enable_q;
		rdata_d            = 8'h00;
		if (soft_clear) begin
			interrupt_enable_d = ENABLE_RESET;
			kernel_enable_d    = KERNEL_EN_RESET;
		end else if (sfr_wr) begin
			if (sfr_addr == ENABLE_ADDR) begin
				interrupt_enable_d = sfr_wdata & ENABLE_WR_MASK;
			end
			if (sfr_addr == KERNEL_EN_ADDR) begin
				kernel_enable_d = sfr_wdata & KERNEL_EN_MASK;
			end
		end
		// Unmapped addresses read as zero
		if (sfr_rd) begin
			case (sfr_addr)
				ENABLE_ADDR:    rdata_d = interrupt_enable_q;
				KERNEL_EN_ADDR: rdata_d = kernel_enable_q;
				default:        rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			interrupt_enable_q <= ENABLE_RESET;
			kernel_enable_q    <= KERNEL_EN_RESET;
			rdata_q            <= 8'h00;
		end else begin
			interrupt_enable_q <= interrupt_enable_d;
			kernel_enable_q    <= kernel_enable_d;
			rdata_q            <= rdata_d;
		end
	end

	assign sfr_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Merged line, unused pin sources, gating

	logic                 merged_line_n_q;
	logic                 merged_line_n_d;
	logic                 ext_zero_q;
	logic                 ext_one_q;
	logic [SRC_COUNT-1:0] src_pending;
	logic [SRC_COUNT-1:0] src_enable;

	// Level, not edge: stays low as long as any internal source pends
	always_comb begin
		merged_line_n_d = ~(|internal_pending);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			merged_line_n_q <= 1'b1;
			ext_zero_q      <= 1'b0;
			ext_one_q       <= 1'b0;
		end else begin
			merged_line_n_q <= merged_line_n_d;
			ext_zero_q      <= 1'b0;
			ext_one_q       <= 1'b0;
		end
	end

	assign merged_internal_irq_line_n = merged_line_n_q;
	assign external_pin_irq_zero      = ext_zero_q;
	assign external_pin_irq_one       = ext_one_q;

	// Source order matches the package indices
	always_comb begin
		src_pending = {kernel_tick_pending, ~merged_line_n_q,
			serial_port_pending, timer_one_pending, timer_zero_pending};
		src_enable  = {kernel_enable_q[KERNEL_BIT],
			interrupt_enable_q[MERGED_BIT],
			interrupt_enable_q[SERIAL_BIT],
			interrupt_enable_q[TIMER1_BIT],
			interrupt_enable_q[TIMER0_BIT]};
	end

	irq_gate #(
		.N(SRC_COUNT)
	) u_gate (
		.clk      (clk),
		.resetn   (resetn),
		.pending  (src_pending),
		.enable   (src_enable),
		.global_en(interrupt_enable_q[GLOBAL_BIT]),
		.request  (irq_request)
	);

	////////////////////////////////////////////////////////////////////////////
	// Vectoring sequence

	flow_type    state_q;
	flow_type    state_d;
	logic [2:0]  extra_q;
	logic [2:0]  extra_d;
	logic        jump_valid_q;
	logic        jump_valid_d;
	logic [15:0] jump_addr_q;
	logic [15:0] jump_addr_d;
	logic        instr_tick;

	instr_tick_gen #(
		.CLKS_PER_INSTR(CLKS_PER_INSTR)
	) u_tick (
		.clk   (clk),
		.resetn(resetn),
		.run   (state_q == MERGED_DELAY),
		.tick  (instr_tick)
	);

	// Service requests outside RUN are ignored; the core waits for jump_valid
	always_comb begin
		state_d      = state_q;
		extra_d      = extra_q;
		jump_valid_d = 1'b0;
		jump_addr_d  = jump_addr_q;
		case (state_q)
			BOOT_WAIT: begin
				if (download_done) begin
					jump_valid_d = 1'b1;
					jump_addr_d  = FW_RESET_VEC;
					state_d      = RUN;
				end
			end
			RUN: begin
				if (service_req) begin
					if (service_src == SRC_MERGED) begin
						extra_d = 3'h0;
						state_d = MERGED_DELAY;
					end else if (service_src <= SRC_KERNEL) begin
						jump_valid_d = 1'b1;
						jump_addr_d  = vector_of(service_src);
					end
				end
			end
			MERGED_DELAY: begin
				if (instr_tick) begin
					if (extra_q == 3'(MERGED_EXTRA_CYCLES - 1)) begin
						jump_valid_d = 1'b1;
						jump_addr_d  = vector_of(SRC_MERGED);
						state_d      = RUN;
					end else begin
						extra_d = extra_q + 3'h1;
					end
				end
			end
			default: begin
				state_d = BOOT_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q      <= BOOT_WAIT;
			extra_q      <= 3'h0;
			jump_valid_q <= 1'b0;
			jump_addr_q  <= 16'h0000;
		end else begin
			state_q      <= state_d;
			extra_q      <= extra_d;
			jump_valid_q <= jump_valid_d;
			jump_addr_q  <= jump_addr_d;
		end
	end

	assign jump_valid = jump_valid_q;
	assign jump_addr  = jump_addr_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	// Helper: cycles spent in the merged delay
	logic [15:0] delay_len_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			delay_len_q <= 16'h0000;
		end else if (state_q == RUN && service_req && service_src == SRC_MERGED) begin
			delay_len_q <= 16'h0000;
		end else if (state_q == MERGED_DELAY) begin
			delay_len_q <= delay_len_q + 16'h0001;
		end
	end

	reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn)
		(interrupt_enable_q & ~ENABLE_WR_MASK) == 8'h00)
		else $error("reserved enable bits not zero");

	global_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		!interrupt_enable_q[GLOBAL_BIT] |=> irq_request == '0)
		else $error("request passed with global gate off");

	timer0_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn) |-> irq_request[SRC_TIMER0] == ($past(timer_zero_pending)
			& $past(interrupt_enable_q[TIMER0_BIT]) & $past(interrupt_enable_q[GLOBAL_BIT])))
		else $error("timer-0 request wrong");

	merged_level_a: assert property (@(posedge clk) disable iff (!resetn)
		(|internal_pending) |=> !merged_internal_irq_line_n)
		else $error("merged line not low while pending");

	pins_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
		!external_pin_irq_zero && !external_pin_irq_one)
		else $error("external pin interrupt requested");

	usb_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		soft_clear |=> interrupt_enable_q == ENABLE_RESET && kernel_enable_q == KERNEL_EN_RESET)
		else $error("usb reset did not clear enables");

	boot_jump_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == BOOT_WAIT && download_done |=> jump_valid && jump_addr == FW_RESET_VEC)
		else $error("boot jump wrong");

	timer1_vec_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == RUN && service_req && service_src == SRC_TIMER1
		|=> jump_valid && jump_addr == 16'h201b)
		else $error("timer-1 vector wrong");

	merged_delay_a: assert property (@(posedge clk) disable iff (!resetn)
		jump_valid && $past(state_q) == MERGED_DELAY
		|-> delay_len_q == 16'(MERGED_EXTRA_CYCLES * CLKS_PER_INSTR + 1)
			&& jump_addr == MERGED_VEC)
		else $error("merged delay length wrong");

endmodule
`default_nettype wire

/* File: irq_vector_pkg.sv */
// Shared constants for the interrupt enable and vectoring block
package irq_vector_pkg;

	// Register addresses on the core's special register port
	localparam logic [7:0]  ENABLE_ADDR     = 8'ha8;
	localparam logic [7:0]  KERNEL_EN_ADDR  = 8'he8;

	// Interrupt enable field positions
	localparam int          TIMER0_BIT      = 1;
	localparam int          TIMER1_BIT      = 3;
	localparam int          SERIAL_BIT      = 4;
	localparam int          MERGED_BIT      = 5;
	localparam int          GLOBAL_BIT      = 7;
	localparam int          KERNEL_BIT      = 0;

	// Writable bits; reserved bits stay zero
	localparam logic [7:0]  ENABLE_WR_MASK  = 8'hba;
	localparam logic [7:0]  KERNEL_EN_MASK  = 8'h01;
	localparam logic [7:0]  ENABLE_RESET    = 8'h00;
	localparam logic [7:0]  KERNEL_EN_RESET = 8'h00;

	// Source indices on the request vector
	localparam int          SRC_COUNT       = 5;
	localparam int          SRC_IDX_W       = 3;
	localparam logic [2:0]  SRC_TIMER0      = 3'h0;
	localparam logic [2:0]  SRC_TIMER1      = 3'h1;
	localparam logic [2:0]  SRC_SERIAL      = 3'h2;
	localparam logic [2:0]  SRC_MERGED      = 3'h3;
	localparam logic [2:0]  SRC_KERNEL      = 3'h4;

	// Relocated firmware vectors
	localparam logic [15:0] FW_RESET_VEC    = 16'h2000;
	localparam logic [15:0] TIMER0_VEC      = 16'h200b;
	localparam logic [15:0] TIMER1_VEC      = 16'h201b;
	localparam logic [15:0] SERIAL_VEC      = 16'h2023;
	localparam logic [15:0] MERGED_VEC      = 16'h202b;
	localparam logic [15:0] KERNEL_VEC      = 16'h2033;

	// Extra boot-code instruction cycles before the merged vector
	localparam int          MERGED_EXTRA_CYCLES = 8;

endpackage

/* File: instr_tick_gen.sv */
// Instruction-cycle enable pulse divider
`timescale 1ns/1ns
`default_nettype none
module instr_tick_gen #(
	parameter int CLKS_PER_INSTR = 4
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic run,
	output logic      tick
);
	localparam int CW = (CLKS_PER_INSTR > 1) ? $clog2(CLKS_PER_INSTR) : 1;

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          tick_q;
	logic          tick_d;

	// Restart whenever idle so every delay starts phase-aligned
	always_comb begin
		cnt_d  = '0;
		tick_d = 1'b0;
		if (run) begin
			if (cnt_q == CW'(CLKS_PER_INSTR - 1)) begin
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule
`default_nettype wire

/* File: irq_gate.sv */
// Per-source enable gating with a global gate, registered
`timescale 1ns/1ns
`default_nettype none
module irq_gate #(
	parameter int N = 5
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [N-1:0] pending,
	input  wire logic [N-1:0] enable,
	input  wire logic         global_en,
	output logic      [N-1:0] request
);
	logic [N-1:0] req_q;
	logic [N-1:0] req_d;

	// All three terms must hold in the same cycle
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_src
			always_comb begin
				req_d[g] = pending[g] & enable[g] & global_en;
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!resetn) begin
			req_q <= '0;
		end else begin
			req_q <= req_d;
		end
	end

	assign request = req_q;
endmodule
`default_nettype wire

/* File: core_model.sv */
// Behavioural model of the microcontroller core on the register and vector port
`timescale 1ns/1ns
`default_nettype none
module core_model (
	input  wire logic        clk,
	input  wire logic [7:0]  sfr_rdata,
	input  wire logic        jump_valid,
	input  wire logic [15:0] jump_addr,
	output logic      [7:0]  sfr_addr,
	output logic             sfr_wr,
	output logic             sfr_rd,
	output logic      [7:0]  sfr_wdata,
	output logic             service_req,
	output logic      [2:0]  service_src,
	output logic             download_done
);
	// Firmware vector table sits here, not at address zero
	localparam logic [15:0] TABLE_BASE = 16'h2000;

	////////////////////////////////////////////////////////////////////////////////
	// Idle bus at time zero
	initial begin
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		service_req = 1'b0;
		download_done = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		service_src = 3'h0;
	end

	// One-cycle strobe; afterwards address and data are inverted and the strobes cleared, so stale values never look valid
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = wr;
		sfr_rd = !wr;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~d;
		q = sfr_rdata;
	endtask

	// Service request or download end; waits a bounded time for the jump
	task automatic svc(input logic [2:0] src, input logic boot, output int cycles,
			output logic [15:0] offset);
		@(posedge clk);
		#1;
		service_src = src;
		service_req = !boot;
		download_done = boot;
		@(posedge clk);
		#1;
		service_req = 1'b0;
		download_done = 1'b0;
		service_src = ~src;
		cycles = 1;
		while (jump_valid !== 1'b1 && cycles < 64) begin
			@(posedge clk);
			#1;
			cycles++;
		end
		offset = jump_addr - TABLE_BASE;
	endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench for the interrupt enable and vectoring block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import irq_vector_pkg::*;
	// One clock per instruction keeps the merged delay short
	localparam int CPI = 1;
	localparam logic [7:0] PATS [6] = '{8'h82, 8'h88, 8'h90, 8'ha0, 8'h3a, 8'hba};
	localparam logic [15:0] VECS [5] = '{16'h200b, 16'h201b, 16'h2023, 16'h202b, 16'h2033};
	logic        clk, resetn, usb_bus_reset, usb_prop, sfr_wr, sfr_rd;
	logic        t0_pend, t1_pend, ser_pend, ker_pend, merged_n, ext0, ext1;
	logic        download_done, service_req, jump_valid;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, int_pend, q;
	logic [4:0]  irq_request, exp;
	logic [2:0]  service_src;
	logic [15:0] jump_addr, off;
	int          num_errors, checks_done, cyc;

	irq_vector_ctrl #(.INT_SRC_N(8), .CLKS_PER_INSTR(CPI)) u_dut (.clk(clk), .resetn(resetn),
		.usb_bus_reset(usb_bus_reset), .usb_reset_propagate_enable(usb_prop),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .timer_zero_pending(t0_pend), .timer_one_pending(t1_pend),
		.serial_port_pending(ser_pend), .internal_pending(int_pend),
		.kernel_tick_pending(ker_pend), .irq_request(irq_request),
		.merged_internal_irq_line_n(merged_n), .external_pin_irq_zero(ext0),
		.external_pin_irq_one(ext1), .download_done(download_done),
		.service_req(service_req), .service_src(service_src), .jump_valid(jump_valid),
		.jump_addr(jump_addr));

	core_model u_core (.clk(clk), .sfr_rdata(sfr_rdata), .jump_valid(jump_valid),
		.jump_addr(jump_addr), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .service_req(service_req), .service_src(service_src),
		.download_done(download_done));

	////////////////////////////////////////////////////////////////////////////////
	// Compare, report and close
	task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
		checks_done++;
		if (seen !== expv) begin
			num_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One-edge pulse of the USB bus reset
	task automatic usb_pulse;
		usb_bus_reset = 1'b1;
		@(posedge clk);
		#1;
		usb_bus_reset = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog; the tests need well under a thousand cycles
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		repeat (4000) @(posedge clk);
		num_errors++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		num_errors = 0;
		checks_done = 0;
		resetn = 1'b0;
		usb_bus_reset = 1'b0;
		usb_prop = 1'b0;
		{t0_pend, t1_pend, ser_pend, ker_pend} = 4'h0;
		int_pend = 8'h00;
		repeat (16) @(posedge clk);
		#1;
		resetn = 1'b1;
		chk({15'h0000, merged_n}, 16'h0001);
		chk({14'h0000, ext0, ext1}, 16'h0000);
		u_core.xfer(1'b0, ENABLE_ADDR, 8'h00, q);
		chk({8'h00, q}, 16'h0000);
		u_core.xfer(1'b0, KERNEL_EN_ADDR, 8'h00, q);
		chk({8'h00, q}, 16'h0000);
		// Reserved enable bits must stay zero after an all-ones write
		u_core.xfer(1'b1, ENABLE_ADDR, 8'hff, q);
		u_core.xfer(1'b0, ENABLE_ADDR, 8'h00, q);
		chk({8'h00, q}, 16'h00ba);
		u_core.xfer(1'b0, 8'h55, 8'h00, q);
		chk({8'h00, q}, 16'h0000);
		// Every source pending; walk enable patterns, kernel gate toggling
		{t0_pend, t1_pend, ser_pend, ker_pend} = 4'hf;
		int_pend = 8'h80;
		repeat (2) @(posedge clk);
		#1;
		chk({15'h0000, merged_n}, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			u_core.xfer(1'b1, ENABLE_ADDR, PATS[i], q);
			u_core.xfer(1'b1, KERNEL_EN_ADDR, {7'h00, i[0]}, q);
			repeat (2) @(posedge clk);
			#1;
			exp = {i[0], PATS[i][5], PATS[i][4], PATS[i][3], PATS[i][1]} & {5{PATS[i][7]}};
			chk({11'h000, irq_request}, {11'h000, exp});
		end
		// Timer-0 and internal sources withdrawn: requests and merged line follow
		t0_pend = 1'b0;
		int_pend = 8'h00;
		repeat (3) @(posedge clk);
		#1;
		chk({11'h000, irq_request}, 16'h0016);
		chk({15'h0000, merged_n}, 16'h0001);
		int_pend = 8'h01;
		repeat (3) @(posedge clk);
		#1;
		chk({15'h0000, merged_n}, 16'h0000);
		// Service before the boot jump is ignored
		u_core.svc(SRC_TIMER0, 1'b0, cyc, off);
		chk(16'(cyc), 16'd64);
		u_core.svc(3'h0, 1'b1, cyc, off);
		chk(off, 16'h0000);
		chk(16'(cyc), 16'd1);
		for (int s = 0; s < 5; s++) begin
			u_core.svc(s[2:0], 1'b0, cyc, off);
			chk(off, VECS[s] - 16'h2000);
			chk(16'(cyc), (s == 3) ? 16'(MERGED_EXTRA_CYCLES * CPI + 2) : 16'd1);
		end
		// USB reset clears enables only with propagation on
		usb_pulse();
		u_core.xfer(1'b0, ENABLE_ADDR, 8'h00, q);
		chk({8'h00, q}, 16'h00ba);
		usb_prop = 1'b1;
		usb_pulse();
		u_core.xfer(1'b0, ENABLE_ADDR, 8'h00, q);
		chk({8'h00, q}, 16'h0000);
		u_core.xfer(1'b0, KERNEL_EN_ADDR, 8'h00, q);
		chk({8'h00, q}, 16'h0000);
		// Mid-run reset clears enables and returns to boot wait
		u_core.xfer(1'b1, ENABLE_ADDR, 8'hff, q);
		resetn = 1'b0;
		@(posedge clk);
		#1;
		resetn = 1'b1;
		u_core.xfer(1'b0, ENABLE_ADDR, 8'h00, q);
		chk({8'h00, q}, 16'h0000);
		u_core.svc(SRC_SERIAL, 1'b0, cyc, off);
		chk(16'(cyc), 16'd64);
		conclude();
	end
endmodule
`default_nettype wire
